// File: sfpi_map.vh
// Constants for the serial flash pin interface
// Contract
// - Serial traffic is honoured only while select is low; high gives standby once core_busy is low and no abort wait is counting.
// - Command, address and data bits are captured on serial clock rising edges.
// - Output data changes on serial clock falling edges.
// - In dual mode both data pins become lanes; one driver per lane.
// - With write guard low, the status lock bit protection is enforced.
// - Pause low suspends the exchange; it resumes where it stopped.
// - Both clock mode 0 and mode 3 work.
// - Page program accepts at most 256 bytes.
// - Erase sizes are 4K, 64K and the full array.
// - Write suspend reaches standby in under 20 us.
// - Software reset reaches standby in under 40 us.
// - Clock level at select fall picks mode 0 (low) or mode 3 (high).
// - Exchange is in 8-bit units; commands act after the full byte.
`ifndef SFPI_MAP_VH
`define SFPI_MAP_VH
`define SFPI_BYTE_BITS       4'h8
`define SFPI_PAGE_BYTES      9'h100
`define SFPI_SMALL_ERASE     24'h001000
`define SFPI_LARGE_ERASE     24'h010000
`define SFPI_ARRAY_BYTES     24'h100000
`define SFPI_SUSPEND_NS      20000
`define SFPI_RESET_NS        40000
`define SFPI_CLK_NS          10
`define SFPI_SUSPEND_CYC     ((`SFPI_SUSPEND_NS / `SFPI_CLK_NS) - 1)
`define SFPI_RESET_CYC       ((`SFPI_RESET_NS / `SFPI_CLK_NS) - 1)
`define SFPI_OP_WREN         8'h06
`define SFPI_OP_WRDI         8'h04
`define SFPI_OP_RDSR         8'h05
`define SFPI_OP_WRSR         8'h01
`define SFPI_OP_READ         8'h03
`define SFPI_OP_FAST         8'h0B
`define SFPI_OP_DUAL         8'h3B
`define SFPI_OP_PROG         8'h02
`define SFPI_OP_PROGL        8'h0A
`define SFPI_OP_SERA         8'h20
`define SFPI_OP_SERA2        8'hD7
`define SFPI_OP_LERA         8'hD8
`define SFPI_OP_AERA         8'h60
`define SFPI_OP_AERA2        8'hC7
`define SFPI_OP_SUSP         8'hB0
`define SFPI_OP_RSTEN        8'h66
`define SFPI_OP_RST          8'h99
`define SFPI_STAT_LOCK_BIT   7
`define SFPI_STAT_RESET      8'h00
`endif

// File: sfpi_top.v
// Serial flash pin interface: pin front end, command decoder, data FIFO
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_map.vh"

module sfpi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full;
  wire            empty;
  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];
  always @(posedge mclk)
  begin
    if (in_valid && !full)
      mem[wr_q[AW-1:0]] <= in_data;
  end
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wr_q <= wr_q + 1'b1;
      if (out_ready && !empty)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // sfpi_fifo

module sfpi_top #(
  parameter SUSPEND_CYC = `SFPI_SUSPEND_CYC,
  parameter RESET_CYC   = `SFPI_RESET_CYC
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // Serial pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        dual_lane_0_i,
  output reg         dual_lane_0_o,
  output reg         dual_lane_0_oe_n,
  input  wire        dual_lane_1_i,
  output reg         dual_lane_1_o,
  output reg         dual_lane_1_oe_n,
  input  wire        wp_n,
  input  wire        hold_n,
  // Memory core side
  input  wire        core_busy,
  input  wire        rd_valid,
  output reg         rd_ready,
  input  wire [7:0]  rd_data,
  output reg         prog_valid,
  input  wire        prog_ready,
  output reg  [7:0]  prog_data,
  output reg  [23:0] op_addr,
  output reg  [23:0] erase_size,
  output reg         erase_pulse,
  output reg         prog_start,
  output reg         core_abort,
  output reg         standby,
  output reg         mode3,
  output reg         stat_write_ok
);
  localparam ST_CMD  = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMY = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_PROG = 3'h4;
  localparam ST_STAT = 3'h5;
  localparam ST_IDLE = 3'h6;

  // Two-stage synchronisers; stage one is read only by stage two
  reg [5:0] s1_q;
  reg [5:0] s2_q;
  reg       sck_prev_q;
  reg       cs_prev_q;
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q       <= 6'h31;
      s2_q       <= 6'h31;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      s1_q       <= {wp_n, hold_n, dual_lane_1_i, dual_lane_0_i, sck, cs_n};
      s2_q       <= s1_q;
      sck_prev_q <= s2_q[1];
      cs_prev_q  <= s2_q[0];
    end
  end
  wire sel    = !s2_q[0];
  wire paused = !s2_q[4];
  wire rise   = sel && !paused && s2_q[1] && !sck_prev_q;
  wire fall   = sel && !paused && !s2_q[1] && sck_prev_q;
  wire cs_fall = cs_prev_q && !s2_q[0];

  reg [2:0]  st_q;
  reg [7:0]  cmd_q;
  reg [7:0]  sh_q;
  reg [2:0]  bit_q;
  reg [1:0]  abyte_q;
  reg [8:0]  pcnt_q;
  reg [7:0]  tx_q;
  reg        dual_q;
  reg        rst_arm_q;
  reg [7:0]  stat_q;
  reg [15:0] wait_q;
  wire       byte_in = rise && (bit_q == 3'h7);
  wire [7:0] nbyte   = {sh_q[6:0], s2_q[2]};
  wire       f_valid;
  wire [7:0] f_data;
  wire       f_ready;
  reg        f_push;

  // Program data is buffered so a slow core can stall its drain side
  sfpi_fifo #(.WIDTH(8), .DEPTH(32), .AW(5)) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (f_push),
    .in_ready  (f_ready),
    .in_data   (sh_q),
    .out_valid (f_valid),
    .out_ready (prog_ready && prog_valid),
    .out_data  (f_data)
  );

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE; cmd_q <= 8'h00; sh_q <= 8'h00; bit_q <= 3'h0;
      abyte_q <= 2'h0; pcnt_q <= 9'h000; tx_q <= 8'h00; dual_q <= 1'b0;
      rst_arm_q <= 1'b0; stat_q <= `SFPI_STAT_RESET; wait_q <= 16'h0000;
      f_push <= 1'b0; op_addr <= 24'h000000; erase_size <= 24'h000000;
      erase_pulse <= 1'b0; prog_start <= 1'b0; core_abort <= 1'b0;
      standby <= 1'b1; mode3 <= 1'b0; stat_write_ok <= 1'b1; rd_ready <= 1'b0;
      prog_valid <= 1'b0; prog_data <= 8'h00;
      dual_lane_0_o <= 1'b0; dual_lane_0_oe_n <= 1'b1;
      dual_lane_1_o <= 1'b0; dual_lane_1_oe_n <= 1'b1;
    end
    else
    begin
      f_push      <= 1'b0;
      erase_pulse <= 1'b0;
      prog_start  <= 1'b0;
      rd_ready    <= 1'b0;
      stat_write_ok <= s2_q[5] || !stat_q[`SFPI_STAT_LOCK_BIT];
      if (prog_ready && prog_valid)
        prog_valid <= 1'b0;
      else if (!prog_valid && f_valid)
      begin
        prog_valid <= 1'b1;
        prog_data  <= f_data;
      end
      if (wait_q != 16'h0000)
      begin
        wait_q <= wait_q - 16'h0001;
        if (wait_q == 16'h0001)
        begin
          core_abort <= 1'b0;
          standby    <= 1'b1;
        end
      end
      if (cs_fall)
      begin
        mode3   <= s2_q[1];
        standby <= 1'b0;
        st_q    <= ST_CMD;
        bit_q   <= 3'h0;
        abyte_q <= 2'h0;
        pcnt_q  <= 9'h000;
      end
      else if (!sel)
      begin
        st_q <= ST_IDLE;
        dual_lane_1_oe_n <= 1'b1;
        dual_lane_0_oe_n <= 1'b1;
        dual_q <= 1'b0;
        if (!core_busy && wait_q == 16'h0000)
          standby <= 1'b1;
      end
      else if (paused)
      begin
        dual_lane_1_oe_n <= 1'b1;
        dual_lane_0_oe_n <= 1'b1;
      end
      else
      begin
        if (st_q == ST_READ || st_q == ST_STAT)
        begin
          dual_lane_1_oe_n <= 1'b0;
          dual_lane_0_oe_n <= !dual_q;
        end
        if (rise)
        begin
          sh_q  <= nbyte;
          bit_q <= bit_q + (dual_q ? 3'h2 : 3'h1);
        end
        if (fall && (st_q == ST_READ || st_q == ST_STAT))
        begin
          dual_lane_1_o <= tx_q[7];
          dual_lane_0_o <= tx_q[6];
          tx_q  <= dual_q ? {tx_q[5:0], 2'b00} : {tx_q[6:0], 1'b0};
          if (bit_q == 3'h0 && st_q == ST_READ)
          begin
            // First bits of a new byte leave on the loading fall, or the host samples a stale bit
            dual_lane_1_o <= rd_data[7];
            dual_lane_0_o <= rd_data[6];
            tx_q     <= dual_q ? {rd_data[5:0], 2'b00} : {rd_data[6:0], 1'b0};
            rd_ready <= rd_valid;
          end
        end
        if (byte_in)
        begin
          case (st_q)
            ST_CMD:
            begin
              cmd_q <= nbyte;
              rst_arm_q <= (nbyte == `SFPI_OP_RSTEN);
              if (nbyte == `SFPI_OP_RST && rst_arm_q)
              begin
                core_abort <= 1'b1; wait_q <= RESET_CYC[15:0];
              end
              else if (nbyte == `SFPI_OP_SUSP)
              begin
                core_abort <= 1'b1; wait_q <= SUSPEND_CYC[15:0];
              end
              else if (nbyte == `SFPI_OP_RDSR)
              begin
                st_q <= ST_STAT; tx_q <= stat_q;
              end
              else if (nbyte == `SFPI_OP_AERA || nbyte == `SFPI_OP_AERA2)
              begin
                op_addr <= 24'h000000; erase_size <= `SFPI_ARRAY_BYTES; erase_pulse <= 1'b1;
              end
              else if (nbyte == `SFPI_OP_WRSR || nbyte == `SFPI_OP_WREN || nbyte == `SFPI_OP_WRDI)
                st_q <= (nbyte == `SFPI_OP_WRSR) ? ST_STAT : ST_IDLE;
              else
                st_q <= ST_ADDR;
            end
            ST_ADDR:
            begin
              op_addr <= {op_addr[15:0], nbyte};
              abyte_q <= abyte_q + 2'h1;
              if (abyte_q == 2'h2)
              begin
                st_q <= ST_IDLE;
                if (cmd_q == `SFPI_OP_READ)
                  st_q <= ST_READ;
                else if (cmd_q == `SFPI_OP_FAST || cmd_q == `SFPI_OP_DUAL)
                  st_q <= ST_DUMY;
                else if (cmd_q == `SFPI_OP_PROG || cmd_q == `SFPI_OP_PROGL)
                begin
                  st_q <= ST_PROG; prog_start <= 1'b1;
                end
                else if (cmd_q == `SFPI_OP_SERA || cmd_q == `SFPI_OP_SERA2 || cmd_q == `SFPI_OP_LERA)
                begin
                  erase_size  <= (cmd_q == `SFPI_OP_LERA) ? `SFPI_LARGE_ERASE : `SFPI_SMALL_ERASE;
                  erase_pulse <= 1'b1;
                end
              end
            end
            ST_READ:
              st_q <= ST_READ;
            ST_DUMY:
            begin
              st_q   <= ST_READ;
              dual_q <= (cmd_q == `SFPI_OP_DUAL);
            end
            ST_PROG:
            begin
              if (pcnt_q != `SFPI_PAGE_BYTES && f_ready)
              begin
                f_push <= 1'b1; pcnt_q <= pcnt_q + 9'h001;
              end
            end
            ST_STAT:
            begin
              if (cmd_q == `SFPI_OP_WRSR && stat_write_ok)
                stat_q <= nbyte;
            end
            default:
              st_q <= ST_IDLE;
          endcase
        end
      end
    end
  end
endmodule // sfpi_top
`default_nettype wire

// File: sfpi_chk_sva.sv
// Concurrent checks on the pins of the serial flash interface
`timescale 1ns/1ps
`default_nettype none
module sfpi_chk #(
  parameter int SUSPEND_CYC = 1999,
  parameter int RESET_CYC   = 3999
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Pins
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        wp_n,
  input wire logic        hold_n,
  input wire logic        dual_lane_0_oe_n,
  input wire logic        dual_lane_1_o,
  input wire logic        dual_lane_1_oe_n,
  // Core side
  input wire logic [23:0] op_addr,
  input wire logic        erase_pulse,
  input wire logic        core_abort,
  input wire logic        standby,
  input wire logic        mode3,
  input wire logic        stat_write_ok
);
  logic [15:0] abort_cnt_q;
  always @(posedge mclk or negedge reset_n)
    if (!reset_n)
      abort_cnt_q <= 16'h0000;
    else
      abort_cnt_q <= core_abort ? abort_cnt_q + 16'h0001 : 16'h0000;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sel_active_a: assert property ($fell(cs_n) |-> ##3 !standby) else $error("standby after select");
  stby_cause_a: assert property ($rose(standby)
    |-> $past(core_abort) || $past(cs_n, 3)) else $error("stray standby");
  idle_float_a: assert property (cs_n [*5] |-> dual_lane_0_oe_n && dual_lane_1_oe_n) else $error("lane driven");
  fall_drive_a: assert property (!dual_lane_1_oe_n && !$past(dual_lane_1_oe_n) && $changed(dual_lane_1_o)
    |-> !sck && !$past(sck)) else $error("output moved off a falling edge");
  hold_float_a: assert property (!hold_n [*4] |-> dual_lane_0_oe_n && dual_lane_1_oe_n) else $error("driven in pause");
  hold_keep_a: assert property (!hold_n [*4] |=> $stable(op_addr)) else $error("address moved in pause");
  guard_off_a: assert property (wp_n [*4] |-> stat_write_ok) else $error("status write blocked");
  mode_pick_a: assert property ($fell(cs_n) |-> ##4 (mode3 == $past(sck, 4))) else $error("wrong clock mode");
  abort_end_a: assert property ($fell(core_abort) |-> ##[0:2] standby) else $error("no standby");
  abort_len_a: assert property (abort_cnt_q <= RESET_CYC + 2) else $error("abort too long");
  abort_span_a: assert property ($fell(core_abort)
    |-> abort_cnt_q == SUSPEND_CYC || abort_cnt_q == RESET_CYC) else $error("abort length off");
  cover property ($rose(mode3));
  cover property (!dual_lane_0_oe_n);
  cover property (erase_pulse);
  cover property ($fell(core_abort));
endmodule // sfpi_chk
bind sfpi_top sfpi_chk #(.SUSPEND_CYC(SUSPEND_CYC), .RESET_CYC(RESET_CYC)) sfpi_chk_i (.mclk(mclk),
  .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .wp_n(wp_n), .hold_n(hold_n), .dual_lane_0_oe_n(dual_lane_0_oe_n),
  .dual_lane_1_o(dual_lane_1_o), .dual_lane_1_oe_n(dual_lane_1_oe_n), .op_addr(op_addr),
  .erase_pulse(erase_pulse), .core_abort(core_abort), .standby(standby), .mode3(mode3),
  .stat_write_ok(stat_write_ok));
`default_nettype wire

// File: sfpi_host.sv
// Host model driving select, serial clock, data and pause pins
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
  // Clock
  input  wire logic mclk,
  // Host pins
  output var  logic cs_n,
  output var  logic sck,
  output var  logic hold_n,
  // Device lanes
  input  wire logic l0_o,
  input  wire logic l0_oe_n,
  input  wire logic l1_o,
  input  wire logic l1_oe_n,
  output wire logic lane0,
  output wire logic lane1
);
  logic mosi, idle;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    hold_n = 1'b1;
    mosi = 1'b0;
    idle = 1'b0;
  end
  // One driver per lane; a released lane0 carries mosi, a released lane1 shows the inverse of l1_o so no stale value survives
  assign lane0 = l0_oe_n ? mosi : l0_o;
  assign lane1 = l1_oe_n ? ~l1_o : l1_o;
  // Clock level is settled well before select falls
  task automatic sel(input logic m3);
    begin
      sck <= m3;
      idle <= m3;
      repeat (8) @(posedge mclk);
      cs_n <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask
  // MSB first, shift on falls, sample on rises; hb picks a bit to pause before
  task automatic xb(input logic [7:0] tx, input int hb, output logic [7:0] rx);
    int i;
    begin
      for (i = 7; i >= 0; i--)
      begin
        if (i == hb)
        begin
          hold_n <= 1'b0;
          repeat (8) @(posedge mclk);
          repeat (4)
          begin
            sck <= ~sck;
            repeat (8) @(posedge mclk);
          end
          hold_n <= 1'b1;
          repeat (8) @(posedge mclk);
        end
        sck <= 1'b0;
        mosi <= tx[i];
        repeat (8) @(posedge mclk);
        sck <= 1'b1;
        rx[i] = l1_oe_n ? 1'bx : l1_o;
        repeat (8) @(posedge mclk);
      end
    end
  endtask
  // Dual read: four clocks per byte, lane1 carries the odd bits
  task automatic xd(output logic [7:0] rx);
    int i;
    begin
      for (i = 3; i >= 0; i--)
      begin
        sck <= 1'b0;
        repeat (8) @(posedge mclk);
        sck <= 1'b1;
        rx[2*i+1] = l1_oe_n ? 1'bx : l1_o;
        rx[2*i] = l0_oe_n ? 1'bx : l0_o;
        repeat (8) @(posedge mclk);
      end
    end
  endtask
  task automatic desel;
    begin
      sck <= idle;
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      repeat (16) @(posedge mclk);
    end
  endtask
endmodule // sfpi_host
`default_nettype wire

// File: tb.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk, reset_n, wp_n, core_busy, rd_valid, prog_ready;
  logic [7:0]  rd_data, rx, pd[3], rb[3], q_rd[$], q_pg[$];
  logic [31:0] lfsr;
  logic [23:0] a, q_er[$], q_ps[$];
  int          num_errors, check_count, n, j, k;
  wire         cs_n, sck, hold_n, lane0, lane1, l0_o, l0_oe_n, l1_o, l1_oe_n;
  wire         rd_ready, prog_valid, erase_pulse, prog_start, core_abort, standby, mode3, stat_write_ok;
  wire [7:0]   prog_data;
  wire [23:0]  op_addr, erase_size;
  logic [7:0]  eop[5] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
  logic [23:0] esz[5] = '{24'h001000, 24'h001000, 24'h010000, 24'h100000, 24'h100000};
  sfpi_top #(.SUSPEND_CYC(5), .RESET_CYC(9)) sfpi_top_i (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
    .dual_lane_0_i(lane0), .dual_lane_0_o(l0_o), .dual_lane_0_oe_n(l0_oe_n), .dual_lane_1_i(lane1),
    .dual_lane_1_o(l1_o), .dual_lane_1_oe_n(l1_oe_n), .wp_n(wp_n), .hold_n(hold_n), .core_busy(core_busy),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_data(prog_data), .op_addr(op_addr), .erase_size(erase_size), .erase_pulse(erase_pulse),
    .prog_start(prog_start), .core_abort(core_abort), .standby(standby), .mode3(mode3), .stat_write_ok(stat_write_ok));
  sfpi_host sfpi_host_i (.mclk(mclk), .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .l0_o(l0_o), .l0_oe_n(l0_oe_n),
    .l1_o(l1_o), .l1_oe_n(l1_oe_n), .lane0(lane0), .lane1(lane1));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference queues of what the core side saw, plus random stalls
  always @(posedge mclk)
  begin
    lfsr <= nxt(lfsr);
    prog_ready <= lfsr[3];
    if (erase_pulse === 1'b1) q_er.push_back(erase_size);
    if (prog_start === 1'b1) q_ps.push_back(op_addr);
    if (prog_valid === 1'b1 && prog_ready === 1'b1) q_pg.push_back(prog_data);
    if (rd_ready === 1'b1)
    begin
      q_rd.push_back(rd_data);
      rd_data <= lfsr[15:8];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      check_count++;
      if (got !== exp)
      begin
        num_errors++;
        $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task automatic cmd(input logic m3, input logic [7:0] op, input int na, input int nd, input int hb);
    begin
      sfpi_host_i.sel(m3);
      sfpi_host_i.xb(op, -1, rx);
      for (k = 2; k >= 3 - na; k--) sfpi_host_i.xb(a[k*8 +: 8], -1, rx);
      for (k = 0; k < nd; k++)
      begin
        sfpi_host_i.xb(pd[k], k == 0 ? hb : -1, rx);
        rb[k] = rx;
      end
      sfpi_host_i.desel();
    end
  endtask
  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    mclk = 1'b0; reset_n = 1'b0; wp_n = 1'b1; core_busy = 1'b0; rd_valid = 1'b1; prog_ready = 1'b1;
    rd_data = 8'hA5; lfsr = 32'h94FABA1C; num_errors = 0; check_count = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(standby, 1, "idle standby");
    chk(stat_write_ok, 1, "idle guard");
    for (j = 0; j < 5; j++)
    begin
      a = {4'h0, lfsr[19:0]};
      cmd(j[0], 8'h06, 0, 0, -1);
      q_er.delete();
      cmd(j[0], eop[j], j < 3 ? 3 : 0, 0, -1);
      chk(mode3, j[0], "mode");
      chk(q_er.size(), 1, "erase count");
      chk(q_er[0], esz[j], "erase size");
      if (j < 3) chk(op_addr, a, "erase addr");
    end
    $display("erase test done");
    a = {4'h0, lfsr[23:4]};
    for (k = 0; k < 3; k++) pd[k] = lfsr[k*8 +: 8] ^ 8'h5A;
    q_rd.delete();
    cmd(1'b1, 8'h03, 3, 3, 3);
    for (k = 0; k < 3; k++) chk(rb[k], q_rd[k], "read byte");
    $display("read test done");
    q_rd.delete();
    sfpi_host_i.sel(1'b0);
    sfpi_host_i.xb(8'h3B, -1, rx);
    for (k = 2; k >= 0; k--) sfpi_host_i.xb(a[k*8 +: 8], -1, rx);
    sfpi_host_i.xb(8'h00, -1, rx);
    for (k = 0; k < 2; k++)
    begin
      sfpi_host_i.xd(rx);
      chk(rx, q_rd[k], "dual byte");
    end
    sfpi_host_i.desel();
    $display("dual test done");
    cmd(1'b0, 8'h06, 0, 0, -1);
    q_pg.delete();
    q_ps.delete();
    cmd(1'b0, 8'h02, 3, 3, -1);
    repeat (40) @(posedge mclk);
    chk(q_pg.size(), 3, "prog count");
    chk(q_ps.size(), 1, "prog start");
    chk(q_ps[0], a, "prog addr");
    for (k = 0; k < 3; k++) chk(q_pg[k], pd[k], "prog byte");
    $display("program test done");
    for (j = 0; j < 3; j++)
    begin
      pd[0] = j == 0 ? 8'h80 : 8'h00;
      cmd(1'b0, 8'h06, 0, 0, -1);
      cmd(1'b0, 8'h01, 0, 1, -1);
      wp_n <= j == 2;
      repeat (6) @(posedge mclk);
      chk(stat_write_ok, j == 2, "guard");
    end
    cmd(1'b0, 8'h05, 0, 1, -1);
    chk(rb[0], 8'h80, "status kept");
    $display("guard test done");
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(standby, 1, "reset standby");
    cmd(1'b0, 8'h05, 0, 1, -1);
    chk(rb[0], 8'h00, "status reset");
    $display("reset test done");
    for (j = 0; j < 2; j++)
    begin
      core_busy <= 1'b1;
      if (j == 1) cmd(1'b0, 8'h66, 0, 0, -1);
      cmd(1'b0, j == 0 ? 8'hB0 : 8'h99, 0, 0, -1);
      for (n = 0; n < 40 && standby !== 1'b1; n++) @(posedge mclk);
      chk(standby, 1, "fast standby");
      core_busy <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    $display("standby test done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
